//--- opl_pkg.sv
// constants, register map and state types of the output pulse and limit
// alarm block; assumes a 40 MHz apb clock
package opl_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int STEP_MS       = 100;
  localparam int TICK_CYCLES   = STEP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SUP_FAIL_MS   = 3000;
  localparam logic [5:0] SUP_TICKS = 6'(SUP_FAIL_MS / STEP_MS);

  // ==========================================================
  // register byte addresses
  localparam logic [7:0] A_OUT_CFG0 = 8'h00;
  localparam logic [7:0] A_OUT_K0   = 8'h10;
  localparam logic [7:0] A_AO_MIN   = 8'h20;
  localparam logic [7:0] A_AO_MAX   = 8'h24;
  localparam logic [7:0] A_AO_GAIN  = 8'h28;
  localparam logic [7:0] A_AO_CFG   = 8'h2c;
  localparam logic [7:0] A_SP_CFG0  = 8'h30;
  localparam logic [7:0] A_SP_PERS  = 8'h38;
  localparam logic [7:0] A_SUP_CFG  = 8'h3c;
  localparam logic [7:0] A_STATUS   = 8'h40;
  localparam logic [7:0] A_MASK     = 8'h44;
  localparam logic [7:0] A_STATE    = 8'h48;
  localparam logic [7:0] A_AO_VAL   = 8'h4c;

  // ==========================================================
  // field positions of an output config word
  localparam int OC_EN   = 0;
  localparam int OC_LINE = 1;
  localparam int OC_ON   = 3;
  localparam int OC_OFF  = 11;
  localparam int OC_SRCB = 19;
  localparam int OC_SRCE = 20;
  // setpoint config word
  localparam int SC_UPPER = 16;
  localparam int SC_EN    = 17;
  localparam int SC_ARCH  = 18;
  localparam int SC_ERR   = 19;
  localparam int SC_CALL  = 20;

  // ==========================================================
  // values
  localparam logic [15:0] AO_LOW_UA  = 16'h0fa0;
  localparam logic [15:0] AO_HIGH_UA = 16'h4e20;
  localparam logic [39:0] ACC_ONE    = 40'h0000000100;
  localparam logic [15:0] K_RESET    = 16'h0100;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ON   = 2'b01,
    PH_OFF  = 2'b11
  } opl_ph_t;

  typedef struct packed {
    logic [31:0]        tick_cnt;
    logic               tick;
    logic [3:0][20:0]   out_cfg;
    logic [3:0][15:0]   out_k;
    logic [3:0][39:0]   acc;
    opl_ph_t [3:0]      ph;
    logic [3:0][7:0]    ph_cnt;
    logic [15:0]        ao_min;
    logic [15:0]        ao_max;
    logic [15:0]        ao_gain;
    logic [2:0]         ao_cfg;
    logic [15:0]        ao_val;
    logic [1:0][20:0]   sp_cfg;
    logic [1:0][7:0]    sp_pers;
    logic [1:0][8:0]    sp_cnt;
    logic [1:0]         sp_alarm;
    logic [2:0]         sup_cfg;
    logic [5:0]         sup_cnt;
    logic               sup_alarm;
    logic [2:0]         status;
    logic [2:0]         mask;
    logic               irq;
    logic [3:0]         lines;
    logic               archive_req;
    logic               call_req;
    logic               error_flag;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
  } opl_state_t;

endpackage : opl_pkg

//--- opl_top.sv
// pulse outputs, current-loop value and limit/supply alarms behind apb
// assumes increments and quantities synchronous to pclk
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
module opl_top
  import opl_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        inc_valid,
  input  wire logic [15:0] base_volume_increment_ch1,
  input  wire logic [15:0] error_base_volume_increment_ch1,
  input  wire logic [15:0] base_flow_ch1,
  input  wire logic [15:0] pressure_ch1,
  input  wire logic        ext_supply_ok,
  output logic             digital_out_line_1,
  output logic             digital_out_line_2,
  output logic             digital_out_line_3,
  output logic             digital_out_line_4,
  output logic      [15:0] analogue_output_value,
  output logic             archive_req,
  output logic             call_req,
  output logic             error_flag,
  output logic             irq
);

  opl_state_t s;
  opl_state_t n;

  function automatic logic [7:0] f_steps(input logic [7:0] m);
    f_steps = (m <= 8'h01) ? 8'h01 : m;
  endfunction : f_steps

  // ==========================================================
  // next state
  logic        wr;
  logic        setup;
  logic        hit;
  logic [31:0] rd;
  logic [16:0] src;
  logic [39:0] prod;
  logic        start;
  logic [1:0][15:0] q;
  logic        exceed;
  logic [2:0]  set;
  logic [16:0] diff;
  logic [31:0] scaled;
  logic [16:0] ao_sum;

  always_comb
  begin
    n = s;
    wr = psel && penable && pwrite && s.pready;
    setup = psel && !penable;
    hit = 1'b1;
    rd = '0;
    set = '0;
    src = '0;
    prod = '0;
    start = 1'b0;
    exceed = 1'b0;
    diff = '0;
    scaled = '0;
    ao_sum = '0;
    q[0] = pressure_ch1;
    q[1] = base_flow_ch1;
    n.archive_req = 1'b0;
    n.call_req = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;

    // 0.1 s timebase
    n.tick = s.tick_cnt >= 32'(TICK_LEN - 1);
    n.tick_cnt = n.tick ? 32'h0 : s.tick_cnt + 32'h1;

    // register decode; reads latch in setup, writes land in access
    case (paddr)
      A_AO_MIN:  rd = {16'h0, s.ao_min};
      A_AO_MAX:  rd = {16'h0, s.ao_max};
      A_AO_GAIN: rd = {16'h0, s.ao_gain};
      A_AO_CFG:  rd = {29'h0, s.ao_cfg};
      A_SP_PERS: rd = {16'h0, s.sp_pers[1], s.sp_pers[0]};
      A_SUP_CFG: rd = {29'h0, s.sup_cfg};
      A_STATUS:  rd = {29'h0, s.status};
      A_MASK:    rd = {29'h0, s.mask};
      A_STATE:   rd = {20'h0, s.sup_alarm, s.sp_alarm, s.error_flag,
                       s.ph[3][0], s.ph[2][0], s.ph[1][0], s.ph[0][0],
                       s.lines};
      A_AO_VAL:  rd = {16'h0, s.ao_val};
      default:
      begin
        hit = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
          if (paddr == A_OUT_CFG0 + 8'(4 * i))
          begin
            hit = 1'b1;
            rd = {11'h0, s.out_cfg[i]};
            if (wr) n.out_cfg[i] = pwdata[20:0];
          end
          if (paddr == A_OUT_K0 + 8'(4 * i))
          begin
            hit = 1'b1;
            rd = {16'h0, s.out_k[i]};
            if (wr) n.out_k[i] = pwdata[15:0];
          end
        end
        for (int j = 0; j < 2; j++)
          if (paddr == A_SP_CFG0 + 8'(4 * j))
          begin
            hit = 1'b1;
            rd = {11'h0, s.sp_cfg[j]};
            if (wr) n.sp_cfg[j] = pwdata[20:0];
          end
      end
    endcase
    if (wr)
      case (paddr)
        A_AO_MIN:  n.ao_min = pwdata[15:0];
        A_AO_MAX:  n.ao_max = pwdata[15:0];
        A_AO_GAIN: n.ao_gain = pwdata[15:0];
        A_AO_CFG:  n.ao_cfg = pwdata[2:0];
        A_SP_PERS: n.sp_pers = pwdata[15:0];
        A_SUP_CFG: n.sup_cfg = pwdata[2:0];
        A_MASK:    n.mask = pwdata[2:0];
        default:   ;
      endcase
    if (setup)
    begin
      n.pready = 1'b1;
      n.prdata = hit ? rd : 32'h0;
      n.pslverr = !hit;
    end

    // pulse outputs
    for (int i = 0; i < 4; i++)
    begin
      src = (s.out_cfg[i][OC_SRCB] ? {1'b0, base_volume_increment_ch1}
                                   : 17'h0)
          + (s.out_cfg[i][OC_SRCE] ? {1'b0, error_base_volume_increment_ch1}
                                   : 17'h0);
      prod = inc_valid ? 40'(src) * 40'(s.out_k[i]) : 40'h0;
      start = 1'b0;
      case (s.ph[i])
        PH_IDLE:
          if (s.tick && s.out_cfg[i][OC_EN] && s.acc[i][39:8] != '0)
          begin
            start = 1'b1;
            n.ph[i] = PH_ON;
            n.ph_cnt[i] = f_steps(s.out_cfg[i][OC_ON +: 8]);
          end
        PH_ON:
          if (s.tick)
          begin
            if (s.ph_cnt[i] <= 8'h01)
            begin
              n.ph[i] = PH_OFF;
              n.ph_cnt[i] = f_steps(s.out_cfg[i][OC_OFF +: 8]);
            end
            else
              n.ph_cnt[i] = s.ph_cnt[i] - 8'h01;
          end
        PH_OFF:
          if (s.tick)
          begin
            if (s.ph_cnt[i] > 8'h01)
              n.ph_cnt[i] = s.ph_cnt[i] - 8'h01;
            else if (s.out_cfg[i][OC_EN] && s.acc[i][39:8] != '0)
            begin
              start = 1'b1;
              n.ph[i] = PH_ON;
              n.ph_cnt[i] = f_steps(s.out_cfg[i][OC_ON +: 8]);
            end
            else
              n.ph[i] = PH_IDLE;
          end
        default: n.ph[i] = PH_IDLE;
      endcase
      n.acc[i] = s.acc[i] + prod - (start ? ACC_ONE : 40'h0);
    end

    // line routing; a line given to the current loop takes no pulses
    n.lines = '0;
    for (int i = 0; i < 4; i++)
      if (n.ph[i] == PH_ON && n.out_cfg[i][OC_EN] &&
          !(n.ao_cfg[0] && n.ao_cfg[2:1] == n.out_cfg[i][OC_LINE +: 2]))
        n.lines[n.out_cfg[i][OC_LINE +: 2]] = 1'b1;

    // current loop target in microamps
    if (base_flow_ch1 <= s.ao_min)
      n.ao_val = AO_LOW_UA;
    else if (base_flow_ch1 >= s.ao_max)
      n.ao_val = AO_HIGH_UA;
    else
    begin
      diff = {1'b0, base_flow_ch1} - {1'b0, s.ao_min};
      scaled = 32'(diff) * 32'(s.ao_gain);
      ao_sum = {1'b0, AO_LOW_UA} + {1'b0, scaled[31:16]};
      n.ao_val = (ao_sum > {1'b0, AO_HIGH_UA}) ? AO_HIGH_UA : ao_sum[15:0];
    end

    // setpoints
    n.error_flag = 1'b0;
    for (int j = 0; j < 2; j++)
    begin
      exceed = s.sp_cfg[j][SC_EN] &&
               (s.sp_cfg[j][SC_UPPER] ? q[j] > s.sp_cfg[j][15:0]
                                      : q[j] < s.sp_cfg[j][15:0]);
      if (!exceed)
        n.sp_cnt[j] = '0;
      else if (s.tick && s.sp_cnt[j] != 9'h1ff)
        n.sp_cnt[j] = s.sp_cnt[j] + 9'h001;
      n.sp_alarm[j] = exceed && s.sp_cnt[j] > {1'b0, s.sp_pers[j]};
      if (n.sp_alarm[j] && !s.sp_alarm[j])
      begin
        set[j] = 1'b1;
        n.archive_req = n.archive_req | s.sp_cfg[j][SC_ARCH];
        n.call_req = n.call_req | s.sp_cfg[j][SC_CALL];
      end
      if (n.sp_alarm[j] && s.sp_cfg[j][SC_ERR])
        n.error_flag = 1'b1;
    end

    // external supply
    if (ext_supply_ok)
      n.sup_cnt = '0;
    else if (s.tick && s.sup_cnt != 6'h3f)
      n.sup_cnt = s.sup_cnt + 6'h01;
    n.sup_alarm = !ext_supply_ok && s.sup_cnt > SUP_TICKS;
    if (n.sup_alarm && !s.sup_alarm)
    begin
      set[2] = 1'b1;
      n.archive_req = n.archive_req | s.sup_cfg[0];
      n.call_req = n.call_req | s.sup_cfg[2];
    end
    if (n.sup_alarm && s.sup_cfg[1])
      n.error_flag = 1'b1;

    // sticky status, set beats write-one-to-clear
    n.status = (s.status & ~((wr && paddr == A_STATUS) ? pwdata[2:0]
                                                       : 3'h0)) | set;
    n.irq = |(n.status & n.mask);
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.out_k <= {4{K_RESET}};
      s.ao_val <= AO_LOW_UA;
    end
    else
      s <= n;
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign digital_out_line_1 = s.lines[0];
  assign digital_out_line_2 = s.lines[1];
  assign digital_out_line_3 = s.lines[2];
  assign digital_out_line_4 = s.lines[3];
  assign analogue_output_value = s.ao_val;
  assign archive_req = s.archive_req;
  assign call_req = s.call_req;
  assign error_flag = s.error_flag;
  assign irq = s.irq;

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_sup_rise;
    $rose(s.sup_alarm);
  endsequence
  sequence s_sp_rise;
    $rose(s.sp_alarm[0]);
  endsequence
  property p_phase_on_tick;
    $changed(s.ph[0]) |-> $past(s.tick);
  endproperty
  a_phase_on_tick: assert property (p_phase_on_tick)
    else $error("pulse phase changed off the timebase");

  property p_gap_follows;
    ($past(s.ph[0]) == PH_ON && s.ph[0] != PH_ON) |-> s.ph[0] == PH_OFF;
  endproperty
  a_gap_follows: assert property (p_gap_follows)
    else $error("pulse ended without a gap");

  property p_route;
    (s.ph[0] == PH_ON && s.out_cfg[0][OC_EN] && !s.ao_cfg[0])
      |-> s.lines[s.out_cfg[0][OC_LINE +: 2]];
  endproperty
  a_route: assert property (p_route)
    else $error("active pulse missing on selected line");

  property p_disabled_quiet;
    s.lines != 4'h0 |-> (s.out_cfg[0][OC_EN] || s.out_cfg[1][OC_EN] ||
                         s.out_cfg[2][OC_EN] || s.out_cfg[3][OC_EN]);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("line driven with all outputs disabled");

  property p_zero_const;
    (inc_valid && s.out_k[0] == 16'h0) |=> s.acc[0] <= $past(s.acc[0]);
  endproperty
  a_zero_const: assert property (p_zero_const)
    else $error("accumulator grew with zero constant");

  property p_ao_range;
    s.ao_val >= AO_LOW_UA && s.ao_val <= AO_HIGH_UA;
  endproperty
  a_ao_range: assert property (p_ao_range)
    else $error("current loop target out of range");

  property p_sp_persist;
    s_sp_rise |-> $past(s.sp_cnt[0]) > {1'b0, $past(s.sp_pers[0])};
  endproperty
  a_sp_persist: assert property (p_sp_persist)
    else $error("setpoint alarm before persistence time");

  property p_sup_persist;
    s_sup_rise |-> $past(s.sup_cnt) > SUP_TICKS;
  endproperty
  a_sup_persist: assert property (p_sup_persist)
    else $error("supply alarm before 3 s");

  property p_sup_clear;
    ext_supply_ok |=> !s.sup_alarm;
  endproperty
  a_sup_clear: assert property (p_sup_clear)
    else $error("supply alarm with supply present");

  property p_pulse_has_unit;
    ($past(s.ph[0]) != PH_ON && s.ph[0] == PH_ON)
      |-> $past(s.acc[0][39:8]) != '0;
  endproperty
  a_pulse_has_unit: assert property (p_pulse_has_unit)
    else $error("pulse started with nothing pending");
endmodule : opl_top

//--- opl_pulse_counter.sv
// far-side model: external counters and dispatch inputs that watch the
// pulse lines and the archive and call strobes; assumes one pclk domain
`timescale 1ns/1ps
module opl_pulse_counter (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  lines,
  input  wire logic        archive_req,
  input  wire logic        call_req,
  output logic [3:0][7:0]  pulses,
  output logic [3:0][15:0] hi_len,
  output logic [3:0][15:0] lo_min,
  output logic [7:0]       arch_cnt,
  output logic [7:0]       call_cnt
);
  logic [3:0]       prev_r;
  logic [3:0]       seen_r;
  logic [3:0][15:0] run_r;

  // ==========================================================
  // edge counting and run lengths of every line
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_r   <= '0;
      seen_r   <= '0;
      run_r    <= '0;
      pulses   <= '0;
      hi_len   <= '0;
      lo_min   <= {4{16'hffff}};
      arch_cnt <= 8'h00;
      call_cnt <= 8'h00;
    end
    else
    begin
      arch_cnt <= arch_cnt + 8'(archive_req);
      call_cnt <= call_cnt + 8'(call_req);
      prev_r   <= lines;
      for (int i = 0; i < 4; i++)
      begin
        if (lines[i] != prev_r[i])
        begin
          run_r[i] <= 16'h0001;
          if (prev_r[i])
            hi_len[i] <= run_r[i];
          else
          begin
            pulses[i] <= pulses[i] + 8'h01;
            seen_r[i] <= 1'b1;
            // gap only counts between two pulses, not before the first
            if (seen_r[i] && run_r[i] < lo_min[i])
              lo_min[i] <= run_r[i];
          end
        end
        else
          run_r[i] <= run_r[i] + 16'h0001;
      end
    end
  end
endmodule : opl_pulse_counter

//--- output_pulse_and_limit_alarm_tb.sv
// self-checking bench of opl_top over apb with a counter model on the lines
// assumes the package's register map and a shortened tick of 10 cycles
`timescale 1ns/1ps
module output_pulse_and_limit_alarm_tb;
  import opl_pkg::*;
  localparam int TL = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic inc_valid, ext_supply_ok, archive_req, call_req, error_flag, irq;
  logic [15:0] base_inc, err_inc, flow, press, ao;
  logic [3:0]  lines;
  logic [3:0][7:0]  pulses;
  logic [3:0][15:0] hi_len, lo_min;
  logic [7:0]  arch_cnt, call_cnt;
  int fail_count, comparisons;

  // ==========================================================
  // design and far-side model
  opl_top #(.TICK_LEN(TL)) opl_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .inc_valid(inc_valid),
    .base_volume_increment_ch1(base_inc),
    .error_base_volume_increment_ch1(err_inc),
    .base_flow_ch1(flow), .pressure_ch1(press),
    .ext_supply_ok(ext_supply_ok),
    .digital_out_line_1(lines[0]), .digital_out_line_2(lines[1]),
    .digital_out_line_3(lines[2]), .digital_out_line_4(lines[3]),
    .analogue_output_value(ao), .archive_req(archive_req),
    .call_req(call_req), .error_flag(error_flag), .irq(irq));

  opl_pulse_counter opl_pulse_counter_i (
    .pclk(pclk), .presetn(presetn), .lines(lines),
    .archive_req(archive_req), .call_req(call_req), .pulses(pulses),
    .hi_len(hi_len), .lo_min(lo_min), .arch_cnt(arch_cnt),
    .call_cnt(call_cnt));

  always #12.5 pclk = ~pclk;

  // ==========================================================
  // tasks
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
    begin
      fail_count++;
      tally_and_finish();
    end
    rd      = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rd_chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_cyc

  task automatic wait_flag(ref logic f, input int bound);
    int n;
    for (n = 0; n < bound && f !== 1'b1; n++)
      @(posedge pclk);
    if (n == bound)
    begin
      fail_count++;
      tally_and_finish();
    end
  endtask : wait_flag

  // ==========================================================
  // scenarios
  initial
  begin
    pclk          = 1'b0;
    presetn       = 1'b0;
    psel          = 1'b0;
    penable       = 1'b0;
    pwrite        = 1'b0;
    paddr         = 8'h00;
    pwdata        = 32'h0;
    inc_valid     = 1'b0;
    base_inc      = 16'h0;
    err_inc       = 16'h0;
    flow          = 16'h0;
    press         = 16'h0;
    ext_supply_ok = 1'b1;
    fail_count    = 0;
    comparisons   = 0;
    wait_cyc(8);
    presetn <= 1'b1;
    check(32'(ao), 32'(AO_LOW_UA));
    rd_chk(A_OUT_K0, 32'(K_RESET));
    rd_chk(A_MASK, 32'h0);
    rd_chk(8'h80, 32'h0);
    check(32'(pslverr), 32'h1);
    // pulses: out0 base+err line 2, out1 base x2 line 3, out2 off line 1
    apb(1'b1, A_OUT_CFG0, 32'h0018_0003);
    apb(1'b1, A_OUT_CFG0 + 8'h04, 32'h0008_101d);
    apb(1'b1, A_OUT_CFG0 + 8'h08, 32'h0008_0008);
    apb(1'b1, A_OUT_K0 + 8'h04, 32'h0000_0200);
    @(posedge pclk);
    inc_valid <= 1'b1;
    base_inc  <= 16'h0001;
    err_inc   <= 16'h0001;
    @(posedge pclk);
    err_inc   <= 16'h0000;
    @(posedge pclk);
    inc_valid <= 1'b0;
    wait_cyc(30 * TL);
    check(32'(pulses[1]), 32'h3);
    check(32'(pulses[2]), 32'h4);
    check(32'(pulses[0]), 32'h0);
    check(32'(pulses[3]), 32'h0);
    check(32'(hi_len[1]), 32'(TL));
    check(32'(hi_len[2]), 32'(3 * TL));
    check(32'(lo_min[1]), 32'(TL));
    check(32'(lo_min[2]), 32'(2 * TL));
    // a zero constant keeps the output counter from growing
    apb(1'b1, A_OUT_K0, 32'h0);
    inc_valid <= 1'b1;
    base_inc  <= 16'h0000;
    err_inc   <= 16'h0001;
    @(posedge pclk);
    inc_valid <= 1'b0;
    wait_cyc(3 * TL);
    check(32'(pulses[1]), 32'h3);
    check(32'(pulses[2]), 32'h4);
    // current loop: 0..32000 onto 4000..20000 uA
    apb(1'b1, A_AO_MIN, 32'h0);
    apb(1'b1, A_AO_MAX, 32'h0000_7d00);
    apb(1'b1, A_AO_GAIN, 32'h0000_8000);
    apb(1'b1, A_AO_CFG, 32'h0000_0007);
    flow <= 16'h3e80;
    wait_cyc(3 * TL);
    rd_chk(A_AO_VAL, 32'h0000_2ee0);
    flow <= 16'h9c40;
    wait_cyc(3 * TL);
    check(32'(ao), 32'(AO_HIGH_UA));
    flow <= 16'h0000;
    wait_cyc(3 * TL);
    check(32'(ao), 32'(AO_LOW_UA));
    // setpoints: sp0 upper 120 on pressure, all actions; sp1 lower, none
    apb(1'b1, A_SP_PERS, 32'h0000_0205);
    apb(1'b1, A_SP_CFG0 + 8'h04, 32'h0002_4000);
    press <= 16'h0079;
    apb(1'b1, A_SP_CFG0, 32'h001f_0078);
    wait_cyc(5 * TL);
    check(32'(error_flag), 32'h0);
    wait_flag(error_flag, 3 * TL);
    wait_cyc(2);
    check(32'(arch_cnt), 32'h1);
    check(32'(call_cnt), 32'h1);
    rd_chk(A_STATUS, 32'h3);
    apb(1'b1, A_MASK, 32'h1);
    wait_cyc(2);
    check(32'(irq), 32'h1);
    apb(1'b1, A_STATUS, 32'h1);
    wait_cyc(2);
    check(32'(irq), 32'h0);
    rd_chk(A_STATUS, 32'h2);
    // supply: a 2 s dip is ignored, a failure lasting past 3 s raises the alarm
    apb(1'b1, A_SUP_CFG, 32'h7);
    apb(1'b1, A_MASK, 32'h4);
    ext_supply_ok <= 1'b0;
    wait_cyc(20 * TL);
    ext_supply_ok <= 1'b1;
    wait_cyc(5 * TL);
    rd_chk(A_STATUS, 32'h2);
    check(32'(irq), 32'h0);
    ext_supply_ok <= 1'b0;
    wait_cyc(29 * TL);
    check(32'(irq), 32'h0);
    wait_flag(irq, 5 * TL);
    wait_cyc(2);
    check(32'(arch_cnt), 32'h2);
    check(32'(call_cnt), 32'h2);
    rd_chk(A_STATUS, 32'h6);
    tally_and_finish();
  end
endmodule : output_pulse_and_limit_alarm_tb
